/* hw/cwp_config_protect.sv */
`timescale 1ns/10ps
`default_nettype none
module cwp_config_protect
  import cwp_pkg::*;
#(
  parameter bit          FLASH_256K   = 1'b1,
  parameter logic [3:0]  SILICON_REV  = 4'h1,       // Arbitrary value
  parameter logic [27:0] PART_CODE    = 28'h000_0a5c // Arbitrary value
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [31:0]       nvm_word,
  input  wire logic              prog_req,
  output logic                   prog_grant,
  input  wire logic              boot_wr_req,
  output logic                   boot_wr_allow,
  input  wire logic              pgm_wr_req,
  input  wire logic [ADDR_W-1:0] pgm_wr_addr,
  output logic                   pgm_wr_allow,
  output logic                   programming_pair_one,
  output logic                   programming_pair_two,
  output logic                   programming_pair_three,
  output logic                   programming_pair_four,
  output logic                   debugger_enable,
  output logic                   scan_port_enable,
  output logic                   test_out_drive_enable,
  output logic                   pin_select_lock,
  output logic                   module_disable_lock,
  output logic                   cfg_valid
);
  // ==========================================================
  // State record
  typedef struct packed {
    cwp_fsm_t    fsm;
    logic [31:0] cfg;
    logic [31:0] key;
    logic        pin_lock;
    logic        mod_lock;
    logic        scan_en;
    logic        tdo_en;
    logic [31:0] rdata;
    logic        err;
    logic [3:0]  pairs;
    logic        dbg_en;
  } cwp_state_t;

  // Config reads as all zeros until loaded: fully protected
  localparam cwp_state_t S_RST = '{
    fsm:      CWP_LOAD,
    cfg:      '0,
    key:      KEY_RESET,
    pin_lock: CTRL_RESET[CC_PIN_LOCK],
    mod_lock: CTRL_RESET[CC_MOD_LOCK],
    scan_en:  CTRL_RESET[CC_SCAN_EN],
    tdo_en:   CTRL_RESET[CC_TDO_EN],
    rdata:    '0,
    err:      1'b0,
    pairs:    '0,
    dbg_en:   1'b0
  };

  cwp_state_t  s_q;
  cwp_state_t  s_d;
  logic        run;
  logic        wr_fire;
  logic        mapped;
  logic [31:0] word_in;
  logic [31:0] ctrl_view;
  logic [8:0]  bnd;
  logic        bound_ok;

  assign run = (s_q.fsm == CWP_RUN);
  assign bnd = s_q.cfg[CW_BOUND_HI:CW_BOUND_LO];

  // ==========================================================
  // Word as latched: absent top bits and forced debugger field
  always_comb begin
    word_in = nvm_word;
    if (!FLASH_256K) begin
      word_in[CW_BOUND_HI:CW_BOUND_TOP_LO] = TOP_ONES;
    end
    if (!nvm_word[CW_FLASH_READ_GUARD]) begin
      word_in[CW_DEBUG_HI:CW_DEBUG_LO] = DEBUG_OFF;
    end
  end

  // Runtime control as software sees it; bit 1 is a fixed one
  always_comb begin
    ctrl_view               = '0;
    ctrl_view[CC_PIN_LOCK]  = s_q.pin_lock;
    ctrl_view[CC_MOD_LOCK]  = s_q.mod_lock;
    ctrl_view[CC_SCAN_EN]   = s_q.scan_en;
    ctrl_view[CC_FIXED_ONE] = CTRL_RESET[CC_FIXED_ONE];
    ctrl_view[CC_TDO_EN]    = s_q.tdo_en;
  end

  // ==========================================================
  // APB decode
  always_comb begin
    unique case (paddr)
      OFS_RUNTIME_CTRL,
      OFS_PART_IDENTITY,
      OFS_UNLOCK_KEY,
      OFS_CFG_WORD: mapped = 1'b1;
      default:      mapped = 1'b0;
    endcase
  end

  // Registers never stall once the word is loaded
  assign pready  = run;
  assign wr_fire = psel && penable && pwrite && run;
  assign pslverr = psel && penable && s_q.err;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    unique case (s_q.fsm)
      CWP_LOAD: begin
        // Single sampling point after reset release
        s_d.cfg     = word_in;
        s_d.scan_en = nvm_word[CW_SCAN_EN];
        s_d.dbg_en  = (word_in[CW_DEBUG_HI:CW_DEBUG_LO] != DEBUG_OFF);
        unique case (nvm_word[CW_CHAN_HI:CW_CHAN_LO])
          CHAN_ONE:   s_d.pairs = 4'h1;
          CHAN_TWO:   s_d.pairs = 4'h2;
          CHAN_THREE: s_d.pairs = 4'h4;
          CHAN_FOUR:  s_d.pairs = 4'h8;
        endcase
        s_d.fsm = CWP_RUN;
      end
      CWP_RUN: begin
        s_d.fsm = CWP_RUN;
      end
    endcase

    // Read data prepared while selected; stable into access phase
    if (psel) begin
      s_d.err = !mapped;
      unique case (paddr)
        OFS_RUNTIME_CTRL:  s_d.rdata = ctrl_view;
        OFS_PART_IDENTITY: s_d.rdata = {SILICON_REV, PART_CODE};
        OFS_UNLOCK_KEY:    s_d.rdata = s_q.key;
        OFS_CFG_WORD:      s_d.rdata = s_q.cfg;
        default:           s_d.rdata = '0;
      endcase
    end

    // Writes take effect only in the completing access cycle
    if (wr_fire) begin
      unique case (paddr)
        OFS_UNLOCK_KEY: begin
          s_d.key = pwdata;
        end
        OFS_RUNTIME_CTRL: begin
          s_d.pin_lock = pwdata[CC_PIN_LOCK];
          s_d.mod_lock = pwdata[CC_MOD_LOCK];
          s_d.scan_en  = pwdata[CC_SCAN_EN];
          s_d.tdo_en   = pwdata[CC_TDO_EN];
        end
        default: begin
          s_d.key = s_q.key;
        end
      endcase
    end
  end

  // ==========================================================
  // State register; ce low freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= S_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Protection gates, closed until the word is loaded
  cwp_bound_decode #(
    .FLASH_256K (FLASH_256K)
  ) u_bound (
    .code  (bnd),
    .addr  (pgm_wr_addr),
    .allow (bound_ok)
  );

  assign prog_grant    = run && prog_req && s_q.cfg[CW_FLASH_READ_GUARD];
  assign boot_wr_allow = run && boot_wr_req
                         && s_q.cfg[CW_BOOT_WRITE_GUARD];
  assign pgm_wr_allow  = run && pgm_wr_req && bound_ok;

  // Data outputs straight from flops
  assign prdata                 = s_q.rdata;
  assign programming_pair_one   = s_q.pairs[0];
  assign programming_pair_two   = s_q.pairs[1];
  assign programming_pair_three = s_q.pairs[2];
  assign programming_pair_four  = s_q.pairs[3];
  assign debugger_enable        = s_q.dbg_en;
  assign scan_port_enable       = s_q.scan_en;
  assign test_out_drive_enable  = s_q.tdo_en;
  assign pin_select_lock        = s_q.pin_lock;
  assign module_disable_lock    = s_q.mod_lock;
  assign cfg_valid              = run;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  prog_refuse_a: assert property (
    !s_q.cfg[CW_FLASH_READ_GUARD] |-> !prog_grant
  ) else $error("programmer granted under code protection");

  boot_guard_a: assert property (
    (boot_wr_req && run) |-> (boot_wr_allow == s_q.cfg[CW_BOOT_WRITE_GUARD])
  ) else $error("boot write gate disagrees with guard bit");

  bound_ends_a: assert property (
    ((run && pgm_wr_req && bnd == BOUND_ALL) |-> !pgm_wr_allow)
    and ((run && pgm_wr_req && bnd == BOUND_NONE) |-> pgm_wr_allow)
  ) else $error("all-ones or all-zeros bound decoded wrongly");

  bound_fine_a: assert property (
    ((run && pgm_wr_req && bnd == BOUND_FIRST)
      |-> (pgm_wr_allow == (pgm_wr_addr >= PAGE_BYTES)))
    and ((run && pgm_wr_req && bnd == BOUND_FINE)
      |-> (pgm_wr_allow == (pgm_wr_addr >= ADDR_16K)))
  ) else $error("fine write bound wrong");

  bound_coarse_a: assert property (
    ((run && pgm_wr_req && bnd == BOUND_64K)
      |-> (pgm_wr_allow == (pgm_wr_addr >= ADDR_64K)))
    and ((run && pgm_wr_req && bnd == BOUND_128K)
      |-> (pgm_wr_allow == (pgm_wr_addr >= ADDR_128K)))
    and ((run && pgm_wr_req && bnd == BOUND_256K)
      |-> (pgm_wr_allow == (pgm_wr_addr >= ADDR_256K)))
  ) else $error("coarse write bound wrong");

  pair_select_a: assert property (
    $rose(run) |-> $onehot(s_q.pairs)
      && (s_q.pairs[0] == ($past(nvm_word[CW_CHAN_HI:CW_CHAN_LO]) == CHAN_ONE))
      && (s_q.pairs[3] == ($past(nvm_word[CW_CHAN_HI:CW_CHAN_LO]) == CHAN_FOUR))
  ) else $error("debug pair select wrong");

  scan_seed_a: assert property (
    $rose(run) |-> scan_port_enable == $past(nvm_word[CW_SCAN_EN])
  ) else $error("scan port enable not seeded from word");

  debug_force_a: assert property (
    run && !s_q.cfg[CW_FLASH_READ_GUARD] |-> !debugger_enable
      && s_q.cfg[CW_DEBUG_HI:CW_DEBUG_LO] == DEBUG_OFF
  ) else $error("debugger live under code protection");

  ident_read_a: assert property (
    (psel && !penable && !pwrite && ce && paddr == OFS_PART_IDENTITY)
      |=> prdata == {SILICON_REV, PART_CODE}
  ) else $error("identity read wrong");

  cfg_hold_a: assert property (
    run |=> run && $stable(s_q.cfg) && $stable(s_q.pairs)
  ) else $error("latched configuration changed");

  top_bits_a: assert property (
    run && !FLASH_256K |-> s_q.cfg[CW_BOUND_HI:CW_BOUND_TOP_LO] == TOP_ONES
  ) else $error("absent bound bits not read as ones");

  closed_early_a: assert property (
    !run |-> !prog_grant && !boot_wr_allow && !pgm_wr_allow && !pready
  ) else $error("gate open before configuration loaded");

  debug_open_a: assert property (
    $rose(run) |-> debugger_enable == ($past(nvm_word[CW_FLASH_READ_GUARD])
      && $past(nvm_word[CW_DEBUG_HI:CW_DEBUG_LO]) != DEBUG_OFF)
  ) else $error("debugger enable not taken from word");

  unmapped_read_a: assert property (
    psel && !penable && !mapped && ce |=> prdata == 32'h0000_0000
  ) else $error("unmapped read returned data");
endmodule
`default_nettype wire

/* hw/cwp_pkg.sv */
`default_nettype none
package cwp_pkg;
  // ==========================================================
  // Register map, byte addresses on the APB side
  localparam logic [15:0] OFS_RUNTIME_CTRL  = 16'hf200;
  localparam logic [15:0] OFS_PART_IDENTITY = 16'hf220;
  localparam logic [15:0] OFS_UNLOCK_KEY    = 16'hf230;
  localparam logic [15:0] OFS_CFG_WORD      = 16'hf240;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_000b;
  localparam logic [31:0] KEY_RESET         = 32'h0000_0000;

  // ==========================================================
  // Field positions in config_word_zero
  localparam int CW_FLASH_READ_GUARD = 28;
  localparam int CW_BOOT_WRITE_GUARD = 24;
  localparam int CW_BOUND_HI         = 18;
  localparam int CW_BOUND_LO         = 10;
  localparam int CW_BOUND_TOP_LO     = 17;
  localparam int CW_CHAN_HI          = 4;
  localparam int CW_CHAN_LO          = 3;
  localparam int CW_SCAN_EN          = 2;
  localparam int CW_DEBUG_HI         = 1;
  localparam int CW_DEBUG_LO         = 0;

  // ==========================================================
  // Field positions in runtime_config_control
  localparam int CC_PIN_LOCK  = 13;
  localparam int CC_MOD_LOCK  = 12;
  localparam int CC_SCAN_EN   = 3;
  localparam int CC_FIXED_ONE = 1;
  localparam int CC_TDO_EN    = 0;

  // ==========================================================
  // Write bound codes and addresses
  localparam int          ADDR_W      = 20;
  localparam logic [8:0]  BOUND_NONE  = 9'h1ff;
  localparam logic [8:0]  BOUND_FIRST = 9'h1fe;
  localparam logic [8:0]  BOUND_FINE  = 9'h1ef;
  localparam logic [8:0]  BOUND_64K   = 9'h1bf;
  localparam logic [8:0]  BOUND_128K  = 9'h17f;
  localparam logic [8:0]  BOUND_256K  = 9'h0ff;
  localparam logic [8:0]  BOUND_ALL   = 9'h000;
  localparam logic [19:0] PAGE_BYTES  = 20'h0_0400;
  localparam logic [19:0] ADDR_16K    = 20'h0_4000;
  localparam logic [19:0] ADDR_64K    = 20'h1_0000;
  localparam logic [19:0] ADDR_128K   = 20'h2_0000;
  localparam logic [19:0] ADDR_256K   = 20'h4_0000;
  localparam logic [1:0]  TOP_ONES    = 2'h3;

  // ==========================================================
  // Debug channel and debugger codes
  localparam logic [1:0] CHAN_ONE   = 2'h3;
  localparam logic [1:0] CHAN_TWO   = 2'h2;
  localparam logic [1:0] CHAN_THREE = 2'h1;
  localparam logic [1:0] CHAN_FOUR  = 2'h0;
  localparam logic [1:0] DEBUG_OFF  = 2'h3;

  typedef enum logic {CWP_LOAD, CWP_RUN} cwp_fsm_t;
endpackage
`default_nettype wire

/* hw/cwp_bound_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module cwp_bound_decode
  import cwp_pkg::*;
#(
  parameter bit FLASH_256K = 1'b1
) (
  input  wire logic [8:0]        code,
  input  wire logic [ADDR_W-1:0] addr,
  output logic                   allow
);
  logic [8:0]        code_eff;
  logic [8:0]        steps;
  logic [ADDR_W-1:0] bound;
  logic              all_prot;

  // ==========================================================
  // Upper two bits exist only on the large-flash variant
  assign code_eff = FLASH_256K ? code : {TOP_ONES, code[6:0]};

  // Code to lowest writable address; undefined codes lock everything
  always_comb begin
    all_prot = 1'b0;
    bound    = '0;
    steps    = BOUND_NONE - code_eff;
    if (code_eff == BOUND_NONE) begin
      bound = '0;
    end else if (code_eff >= BOUND_FINE) begin
      bound = ADDR_W'(steps) * PAGE_BYTES;
    end else if (code_eff == BOUND_64K) begin
      bound = ADDR_64K;
    end else if (code_eff == BOUND_128K) begin
      bound = ADDR_128K;
    end else if (code_eff == BOUND_256K) begin
      bound = ADDR_256K;
    end else begin
      // Undefined codes fail safe, same as all zeros
      all_prot = 1'b1;
    end
  end

  assign allow = !all_prot && (addr >= bound);
endmodule
`default_nettype wire

/* bench/cwp_prog_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Programmer and debugger side of the word
module cwp_prog_model (
  input  wire logic        rd_guard,
  input  wire logic        wr_guard,
  input  wire logic [8:0]  bound,
  input  wire logic [1:0]  chan,
  input  wire logic        scan,
  input  wire logic [1:0]  dbg,
  input  wire logic        want,
  output logic      [31:0] nvm_word,
  output logic             prog_req
);
  // Reserved bits always burnt as the programmer must burn them
  assign nvm_word = {1'h0, 2'h3, rd_guard, 3'h7, wr_guard, 5'h1f, bound,
                     5'h1f, chan, scan, dbg};
  // Access request held as a level, no framing
  assign prog_req = want;
endmodule
`default_nettype wire

/* bench/tb_config_word_protection_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_config_word_protection_decode
  import cwp_pkg::*;
;
  localparam logic [3:0]  REV  = 4'h6;        // Arbitrary value
  localparam logic [27:0] PART = 28'h012_3456; // Arbitrary value
  logic              pclk, presetn, ce, psel, penable, pwrite, err;
  logic              pready, pslverr, want, prog_req, prog_grant;
  logic              boot_wr_req, boot_wr_allow, pgm_wr_req, pgm_wr_allow;
  logic              pair1, pair2, pair3, pair4, dbg_en, scan_en;
  logic              tdo_en, pin_lock, mod_lock, cfg_valid, small_allow;
  logic [15:0]       paddr, cfg;
  logic [31:0]       pwdata, prdata, nvm_word, rd;
  logic [ADDR_W-1:0] pgm_wr_addr;
  int                fails = 0;
  int                samples_checked = 0;

  // ==========================================
  // Block under test and programmer model
  cwp_config_protect #(.SILICON_REV(REV), .PART_CODE(PART))
    cwp_config_protect_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_word(nvm_word), .prog_req(prog_req), .prog_grant(prog_grant),
    .boot_wr_req(boot_wr_req), .boot_wr_allow(boot_wr_allow),
    .pgm_wr_req(pgm_wr_req), .pgm_wr_addr(pgm_wr_addr),
    .pgm_wr_allow(pgm_wr_allow), .programming_pair_one(pair1),
    .programming_pair_two(pair2), .programming_pair_three(pair3),
    .programming_pair_four(pair4), .debugger_enable(dbg_en),
    .scan_port_enable(scan_en), .test_out_drive_enable(tdo_en),
    .pin_select_lock(pin_lock), .module_disable_lock(mod_lock),
    .cfg_valid(cfg_valid)
  );
  cwp_prog_model cwp_prog_model_inst (
    .rd_guard(cfg[15]), .wr_guard(cfg[14]), .bound(cfg[13:5]),
    .chan(cfg[4:3]), .scan(cfg[2]), .dbg(cfg[1:0]), .want(want),
    .nvm_word(nvm_word), .prog_req(prog_req)
  );
  // Small-flash variant on the same word; only its write gate is judged
  cwp_config_protect #(.FLASH_256K(1'b0)) cwp_config_protect_small_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .nvm_word(nvm_word),
    .prog_req(prog_req), .prog_grant(), .boot_wr_req(boot_wr_req),
    .boot_wr_allow(), .pgm_wr_req(pgm_wr_req), .pgm_wr_addr(pgm_wr_addr),
    .pgm_wr_allow(small_allow), .programming_pair_one(),
    .programming_pair_two(), .programming_pair_three(),
    .programming_pair_four(), .debugger_enable(), .scan_port_enable(),
    .test_out_drive_enable(), .pin_select_lock(), .module_disable_lock(),
    .cfg_valid()
  );

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // The word is only sampled after reset, so each setting needs one
  task automatic load(input logic [15:0] v, input int hold);
    int n;
    n = 0;
    cfg     <= v;
    presetn <= 1'h0;
    repeat (hold) @(posedge pclk);
    chk(32'({cfg_valid, pready, prog_grant}), 32'h0);
    presetn <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (cfg_valid !== 1'h1 && n < 4);
    chk(32'(cfg_valid), 32'h1);
    @(posedge pclk);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs;
    load(16'hffff, 2);
    apb(1'h0, OFS_RUNTIME_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'h1, OFS_PART_IDENTITY, 32'h0);
    apb(1'h0, OFS_PART_IDENTITY, 32'h0);
    chk(rd, {REV, PART});
    apb(1'h0, OFS_UNLOCK_KEY, 32'h0);
    chk(rd, KEY_RESET);
    apb(1'h1, OFS_UNLOCK_KEY, 32'h1234_5678);
    apb(1'h0, OFS_UNLOCK_KEY, 32'h0);
    chk(rd, 32'h1234_5678);
    chk(32'(err), 32'h0);
    // Clock enable low: the completing write edge is frozen out
    ce <= 1'h0;
    apb(1'h1, OFS_UNLOCK_KEY, 32'h0000_abcd);
    ce <= 1'h1;
    apb(1'h0, OFS_UNLOCK_KEY, 32'h0);
    chk(rd, 32'h1234_5678);
    apb(1'h0, OFS_CFG_WORD, 32'h0);
    chk(rd, 32'h7fff_ffff);
    apb(1'h1, OFS_RUNTIME_CTRL, 32'h0000_3000);
    apb(1'h0, OFS_RUNTIME_CTRL, 32'h0);
    chk(rd, 32'h0000_3002);
    chk(32'({pin_lock, mod_lock, scan_en, tdo_en}), 32'hc);
    apb(1'h0, 16'hf210, 32'h0);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    $display("t_regs done");
  endtask

  task automatic t_guards;
    for (int i = 0; i < 4; i++) begin
      load({i[1], i[0], 9'h1ff, 2'h3, 1'h1, 2'h0}, 2);
      want        <= 1'h1;
      boot_wr_req <= 1'h1;
      @(posedge pclk);
      chk(32'(prog_grant), 32'(i[1]));
      chk(32'(boot_wr_allow), 32'(i[0]));
      chk(32'(dbg_en), 32'(i[1]));
      want        <= 1'h0;
      boot_wr_req <= 1'h0;
      @(posedge pclk);
      chk(32'({prog_grant, boot_wr_allow}), 32'h0);
      apb(1'h0, OFS_CFG_WORD, 32'h0);
      chk(32'(rd[1:0]), i[1] ? 32'h0 : 32'h3);
    end
    $display("t_guards done");
  endtask

  // Each code checked at address zero, one below and at its bound
  task automatic t_bound;
    logic [8:0]        code;
    logic [ADDR_W-1:0] bnd;
    logic [ADDR_W-1:0] a;
    logic [8:0]        xc [4];
    logic [ADDR_W-1:0] xb [4];
    logic              exp_small;
    xc = '{BOUND_64K, BOUND_128K, BOUND_256K, BOUND_ALL};
    xb = '{ADDR_64K, ADDR_128K, ADDR_256K, 20'hf_fc00};
    pgm_wr_req <= 1'h1;
    for (int i = 0; i < 21; i++) begin
      code = (i < 17) ? BOUND_NONE - 9'(i) : xc[i-17];
      bnd  = (i < 17) ? PAGE_BYTES * 20'(i) : xb[i-17];
      load({2'h3, code, 2'h3, 1'h1, 2'h3}, 2);
      for (int k = 0; k < 3; k++) begin
        a = (k == 0) ? 20'h0 : bnd - 20'(2 - k);
        pgm_wr_addr <= a;
        @(posedge pclk);
        chk(32'(pgm_wr_allow), 32'(code != 9'h0 && a >= bnd));
        // Small variant reads the absent top bits as ones
        exp_small = i == 18 || i == 19 || (code != 9'h0 && a >= bnd);
        chk(32'(small_allow), 32'(exp_small));
      end
    end
    pgm_wr_req <= 1'h0;
    $display("t_bound done");
  endtask

  task automatic t_chan;
    for (int i = 0; i < 4; i++) begin
      load({2'h3, 9'h1ff, 2'(i), i[0], 2'(i)}, 2);
      chk(32'({pair1, pair2, pair3, pair4}), 32'h1 << i);
      chk(32'(dbg_en), 32'(i != 3));
      chk(32'(scan_en), 32'(i[0]));
      apb(1'h0, OFS_RUNTIME_CTRL, 32'h0);
      chk(rd, 32'h3 | (32'(i[0]) << 3));
    end
    $display("t_chan done");
  endtask

  // Changing the stored word without reset must change nothing
  task automatic t_hold;
    load(16'hffff, 2);
    cfg         <= 16'h0000;
    want        <= 1'h1;
    boot_wr_req <= 1'h1;
    repeat (3) @(posedge pclk);
    chk(32'({prog_grant, boot_wr_allow, dbg_en}), 32'h6);
    apb(1'h0, OFS_CFG_WORD, 32'h0);
    chk(rd, 32'h7fff_ffff);
    want        <= 1'h0;
    boot_wr_req <= 1'h0;
    $display("t_hold done");
  endtask

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    pclk        = 1'h0;
    presetn     = 1'h0;
    ce          = 1'h1;
    psel        = 1'h0;
    penable     = 1'h0;
    pwrite      = 1'h0;
    paddr       = 16'h0000;
    pwdata      = 32'h0000_0000;
    want        = 1'h0;
    boot_wr_req = 1'h0;
    pgm_wr_req  = 1'h0;
    pgm_wr_addr = 20'h0_0000;
    cfg         = 16'hffff;
    load(16'hffff, 10);
    t_regs();
    t_guards();
    t_bound();
    t_chan();
    t_hold();
    conclude();
  end

  // Whole run needs some 300 cycles; this is ample margin
  initial begin
    #200us;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
